// ### rtl/qsg_map.svh
// constants for the questionable status group: bit positions, widths, reset values
`ifndef QSG_MAP_SVH
`define QSG_MAP_SVH
`define QSG_W            16
`define QSG_BIT_VOLT     0
`define QSG_BIT_CURR     1
`define QSG_BIT_TEMP     4
`define QSG_BIT_OVP      9
`define QSG_USED_MASK    16'h0213
`define QSG_EVT_RST      16'h0000
`define QSG_ENA_RST      16'h0000
`define QSG_STB_BIT_QUESTIONABLE_SUMMARY 3
`define QSG_STB_W        8
`endif

// ### rtl/qsg_pkg.sv
// types shared by the questionable status group files
package qsg_pkg;
  // raw condition inputs from the supply
  typedef struct packed {
    logic ovp_trip;
    logic fan_fault;
    logic in_cv;
    logic in_cc;
  } qsg_cond_s;
  // commands from the remote command decoder, one-cycle strobes
  typedef struct packed {
    logic        evt_query;
    logic        ena_query;
    logic        ena_write;
    logic        clr_status;
    logic        dev_reset;
    logic        dev_clear;
    logic [15:0] wdata;
  } qsg_cmd_s;
  typedef logic [15:0] qsg_word_t;
endpackage

// ### rtl/qsg_sync.sv
// three-stage synchroniser with agree filter for one pin
module qsg_sync (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic d,
  output logic      q
);
  logic [2:0] s_r;
  logic [2:0] s_nxt;
  logic       q_r;
  logic       q_nxt;
  // shift; stage 0 is only read by stage 1
  always_comb begin
    s_nxt = {s_r[1:0], d};
    q_nxt = (s_r[1] == s_r[2]) ? s_r[2] : q_r;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= 3'h0;
      q_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule

// ### rtl/qsg_event.sv
// latched event register with clear-on-read, set wins over clear
`include "qsg_map.svh"
module qsg_event
  import qsg_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire qsg_word_t   set_bits,
  input  wire logic        clr,
  output qsg_word_t        evt
);
  qsg_word_t evt_r;
  qsg_word_t evt_nxt;
  // sticky latch; a clear drops old bits but keeps same-cycle new ones
  always_comb begin
    evt_nxt = (clr ? `QSG_EVT_RST : evt_r) | (set_bits & `QSG_USED_MASK);
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) evt_r <= `QSG_EVT_RST;
    else     evt_r <= evt_nxt;
  end
  assign evt = evt_r;
endmodule

// ### rtl/qsg_top.sv
// questionable status group: event latch, enable mask and summary bit
// How it works
// - an event bit latches in every cycle its condition is present, so it sets again after a clear while the condition lasts, and ignores later changes.
// - the event register clears on its query and on a clear-status command.
// - device reset and device clear commands leave event bits alone.
// - a query returns the binary-weighted sum of the set bits, i.e. the word itself.
// - the summary is the OR of event bits whose enable bits are set.
// - the enable mask is read/write, its read does not clear it, written as a bit-weight sum.
// - clear-status leaves the enable mask unchanged.
// - bit 0 latches on entry to constant-current operation (voltage unregulated).
// - bit 1 latches on entry to constant-voltage operation (current unregulated).
// - bit 4 latches on a fan fault.
// - bit 9 latches when the overvoltage protection trips.
// - a dip into constant current latches bit 0 only if it lasts two agreeing samples.
// - the questionable event register clears on clear-status and on its query.
// - the enable mask becomes zero only on RST or when zero is written to it.
// - the summary appears as bit 3 of the status byte.
`include "qsg_map.svh"
module qsg_top
  import qsg_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire qsg_pkg::qsg_cond_s COND,
  input  wire qsg_pkg::qsg_cmd_s  CMD,
  output logic [15:0]             RDATA,
  output logic                    RVALID,
  output logic                    QUESTIONABLE_SUMMARY,
  output logic [7:0]              STB_QUESTIONABLE_SUMMARY
);
  import qsg_pkg::*;

  // ************************************************
  // helper functions
  // ************************************************
  // positions without a condition behind them read as zero
  function automatic qsg_word_t keep_used(input qsg_word_t w);
    keep_used = w & `QSG_USED_MASK;
  endfunction

  // masked or of an event word; unused positions never count
  function automatic logic masked_any(input qsg_word_t e, input qsg_word_t m);
    masked_any = |keep_used(e & m);
  endfunction

  // status byte contribution: only the questionable summary position
  function automatic logic [7:0] status_byte(input logic questionable_summary);
    status_byte                    = 8'h00;
    status_byte[`QSG_STB_BIT_QUESTIONABLE_SUMMARY] = questionable_summary;
  endfunction

  // read answer; an event query beats a mask query in the same cycle
  function automatic qsg_word_t pick_answer(
    input logic      evt_q,
    input logic      ena_q,
    input qsg_word_t evt_w,
    input qsg_word_t ena_w,
    input qsg_word_t held
  );
    if (evt_q) begin
      pick_answer = keep_used(evt_w);
    end else if (ena_q) begin
      pick_answer = ena_w;
    end else begin
      pick_answer = held;
    end
  endfunction

  // ************************************************
  // command decode
  // ************************************************
  logic      do_evt_query;
  logic      do_ena_query;
  logic      do_ena_write;
  logic      do_clr_status;
  logic      do_any_query;
  qsg_word_t wr_word;
  // strobes come from same-clock logic, so they skip the synchronisers
  // device reset and device clear strobes never reach the latch
  always_comb begin
    do_evt_query  = CMD.evt_query;
    do_ena_query  = CMD.ena_query;
    do_ena_write  = CMD.ena_write;
    do_clr_status = CMD.clr_status;
    do_any_query  = CMD.evt_query | CMD.ena_query;
    wr_word       = CMD.wdata;
  end

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic cc_s;
  logic cv_s;
  logic fan_s;
  logic ovp_s;
  qsg_sync u_cc  (.CLK(CLK), .RST(RST), .d(COND.in_cc),     .q(cc_s));
  qsg_sync u_cv  (.CLK(CLK), .RST(RST), .d(COND.in_cv),     .q(cv_s));
  qsg_sync u_fan (.CLK(CLK), .RST(RST), .d(COND.fan_fault), .q(fan_s));
  qsg_sync u_ovp (.CLK(CLK), .RST(RST), .d(COND.ovp_trip),  .q(ovp_s));

  // ************************************************
  // event latch
  // ************************************************
  qsg_word_t set_bits;
  qsg_word_t evt;
  logic      evt_clr;
  // conditions are levels; latching any asserted sample catches short dips
  always_comb begin
    set_bits = `QSG_EVT_RST;
    set_bits[`QSG_BIT_VOLT] = cc_s;
    set_bits[`QSG_BIT_CURR] = cv_s;
    set_bits[`QSG_BIT_TEMP] = fan_s;
    set_bits[`QSG_BIT_OVP]  = ovp_s;
  end
  // reset and device clear not included
  assign evt_clr = do_evt_query | do_clr_status;
  qsg_event u_evt (
    .CLK      (CLK),
    .RST      (RST),
    .set_bits (set_bits),
    .clr      (evt_clr),
    .evt      (evt)
  );

  // ************************************************
  // enable mask
  // ************************************************
  qsg_word_t ena_r;
  qsg_word_t ena_nxt;
  // only a write of zero clears
  always_comb begin
    ena_nxt = ena_r;
    if (do_ena_write) begin
      ena_nxt = wr_word;
    end
  end
  // mask register; no path but RST and a write touches it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ena_r <= `QSG_ENA_RST;
    end else begin
      ena_r <= ena_nxt;
    end
  end

  // ************************************************
  // read data and summary
  // ************************************************
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  // weighted sum is the word; data captured before the clear lands
  always_comb begin
    rvalid_nxt = do_any_query;
    rdata_nxt  = pick_answer(do_evt_query, do_ena_query, evt, ena_r, rdata_r);
  end
  // answer register, held until the next query
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end
  assign RDATA  = rdata_r;
  assign RVALID = rvalid_r;

  logic sum_r;
  logic sum_nxt;
  always_comb begin
    sum_nxt = masked_any(evt, ena_r);
  end
  // registered so the summary never glitches on a same-cycle mask write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sum_r <= 1'b0;
    end else begin
      sum_r <= sum_nxt;
    end
  end
  assign QUESTIONABLE_SUMMARY = sum_r;
  always_comb begin
    STB_QUESTIONABLE_SUMMARY = status_byte(sum_r);
  end
endmodule

// ### bench/qsg_props.sv
// port assertions for the questionable status group
module qsg_props
  import qsg_pkg::*;
(
  input wire logic               CLK,
  input wire logic               RST,
  input wire qsg_pkg::qsg_cond_s COND,
  input wire qsg_pkg::qsg_cmd_s  CMD,
  input wire logic [15:0]        RDATA,
  input wire logic               RVALID,
  input wire logic               QUESTIONABLE_SUMMARY,
  input wire logic [7:0]         STB_QUESTIONABLE_SUMMARY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // answers, mask and summary timing
  q_answer_a: assert property ((CMD.evt_query || CMD.ena_query) |=> RVALID)
    else $error("no answer");
  stray_answer_a: assert property (RVALID |-> $past(CMD.evt_query || CMD.ena_query))
    else $error("stray answer");
  unused_zero_a: assert property (CMD.evt_query |=> (RDATA & 16'hFDEC) == 16'h0000)
    else $error("unused bit set");
  stb_map_a: assert property (STB_QUESTIONABLE_SUMMARY == {4'h0, QUESTIONABLE_SUMMARY, 3'h0})
    else $error("bad status byte");
  mask_read_a: assert property (
    CMD.ena_write && !CMD.ena_query ##1 CMD.ena_query && !CMD.evt_query
    |=> RDATA == $past(CMD.wdata, 2)) else $error("bad mask read");
  clr_empty_a: assert property (
    (COND == 4'h0) [*6] ##0 CMD.clr_status |-> ##2 !QUESTIONABLE_SUMMARY)
    else $error("summary after clear");
  mask_zero_a: assert property (
    CMD.ena_write && CMD.wdata == 16'h0000 ##1 !CMD.ena_write |=> !QUESTIONABLE_SUMMARY)
    else $error("summary with zero mask");
  sum_set_a: assert property (
    CMD.ena_write && CMD.wdata == 16'hFFFF ##1 (COND.ovp_trip && !CMD.ena_write) [*6]
    |=> QUESTIONABLE_SUMMARY) else $error("summary missing");
  cover property (RVALID && RDATA != 16'h0000);
  cover property (QUESTIONABLE_SUMMARY);
  cover property (CMD.clr_status);
endmodule

bind qsg_top qsg_props i_props (.CLK, .RST, .COND, .CMD, .RDATA, .RVALID,
  .QUESTIONABLE_SUMMARY, .STB_QUESTIONABLE_SUMMARY);

// ### bench/qsg_ctl.sv
// remote controller model: one command word per cycle
module qsg_ctl
  import qsg_pkg::*;
(
  input wire logic        CLK,
  input wire logic [15:0] rdata,
  output qsg_pkg::qsg_cmd_s cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  qsg_word_t rd;
  initial cmd = '0;
  task automatic op(input logic [5:0] k, input qsg_word_t w);
    @(negedge CLK);
    rd = rdata; // answer to the previous word
    cmd = {k, w};
  endtask
endmodule

// ### bench/questionable_status_group_tb_top.sv
// self-checking bench for the questionable status group
module questionable_status_group_tb_top import qsg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] EVQ = 6'h20, ENQ = 6'h10, ENW = 6'h08, CLS = 6'h04, DRC = 6'h03;
  logic CLK = 1'b0, RST = 1'b1, summ, rvalid;
  qsg_cond_s cond = '0;
  qsg_cmd_s cmd;
  logic [15:0] rdata;
  logic [7:0] stb;
  int err_total = 0, cmp_count = 0;
  const qsg_word_t wt [4] = '{16'h0001, 16'h0002, 16'h0010, 16'h0200};
  always #2.5 CLK = ~CLK;
  qsg_top i_dut (.CLK, .RST, .COND(cond), .CMD(cmd), .RDATA(rdata), .RVALID(rvalid),
    .QUESTIONABLE_SUMMARY(summ), .STB_QUESTIONABLE_SUMMARY(stb));
  qsg_ctl i_ctl (.CLK, .rdata, .cmd);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) i_ctl.op(6'h00, 16'h0000);
  endtask
  task automatic q(input logic [5:0] k, input qsg_word_t exp);
    i_ctl.op(k, 16'h0000);
    idle(1);
    check(16'(rvalid), 16'h0001);
    check(i_ctl.rd, exp);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // two-cycle dips per condition; the pin filter needs two agreeing samples
  initial begin
    repeat (16) @(negedge CLK);
    RST = 1'b0;
    q(EVQ, 16'h0000);
    q(ENQ, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      cond = qsg_cond_s'(4'h1 << i);
      idle(2);
      cond = '0;
      idle(4);
      i_ctl.op(DRC, 16'h0000);
      idle(1);
      q(EVQ, wt[i]);
      q(EVQ, 16'h0000);
    end
    i_ctl.op(ENW, 16'h0210);
    q(ENQ, 16'h0210);
    q(ENQ, 16'h0210);
    cond = 4'h4;
    idle(2);
    cond = '0;
    idle(6);
    check(16'(summ), 16'h0001);
    check(16'(stb), 16'h0008);
    i_ctl.op(CLS, 16'h0000);
    idle(3);
    check(16'(summ), 16'h0000);
    q(ENQ, 16'h0210);
    q(EVQ, 16'h0000);
    i_ctl.op(ENW, 16'hFFFF);
    cond = 4'h8;
    idle(8);
    check(16'(summ), 16'h0001);
    q(EVQ, 16'h0200);
    q(EVQ, 16'h0200);
    cond = '0;
    i_ctl.op(ENW, 16'h0000);
    idle(3);
    check(16'(summ), 16'h0000);
    print_verdict();
  end
  initial begin
    #5000;
    err_total++;
    print_verdict();
  end
endmodule
